// File: rtl/quinary_i2c_address_select.sv
// Address select and address-match front end of an I2C target LED driver.
// Assumes SCL/SDA are sampled synchronous to the 40 MHz core clock.
// Functional notes
// - The 7-bit address comes only from the three address pads.
// - Each pad resolves to ground, pull-down, floating, pull-up or supply.
// - Pads are sampled and the address latched once the pads settle after reset release.
// - After latching, pads are powered off and not resampled.
// - Address is one plus base-five pad value, high pad most significant.
// - Active-low output enable gates all LED outputs; high turns them off.
// - Active-low hardware reset resets the device and resamples pads.
`timescale 1ns/1ps
`default_nettype none
module quinary_i2c_address_select (
   // Clock and reset.
   input  wire logic                             core_clk_i,
   input  wire logic                             rst_n_i,
   // Address pad level codes from the pad comparators.
   input  wire logic [addr_sel_pkg::LEVEL_W-1:0] addr_pad_low_i,
   input  wire logic [addr_sel_pkg::LEVEL_W-1:0] addr_pad_mid_i,
   input  wire logic [addr_sel_pkg::LEVEL_W-1:0] addr_pad_high_i,
   // Pad bias power control.
   output logic                                  pad_enable_o,
   // Output enable for the LED drivers.
   input  wire logic                             led_enable_n_i,
   output logic                                  led_gate_o,
   // I2C bus.
   input  wire logic                             scl_i,
   input  wire logic                             sda_i,
   output logic                                  sda_o,
   output logic                                  sda_oe_n_o,
   // Status.
   output logic      [addr_sel_pkg::ADDR_W-1:0]  slave_addr_o,
   output logic                                  addr_valid_o,
   output logic                                  addr_match_o
);
   import addr_sel_pkg::*;

   // ===========================================================================
   // Pad sampling sequence
   typedef enum logic [2:0] {
      ST_SETTLE = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_DONE   = 3'b100
   } samp_st_t;

   samp_st_t          st;
   samp_st_t          next_st;
   logic [7:0]        cnt;
   logic [7:0]        next_cnt;
   logic [ADDR_W-1:0] dec_addr;
   logic [ADDR_W-1:0] next_slave_addr;
   logic              next_pad_enable;
   logic              next_addr_valid;

   level_decode u_dec (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .lvl_low_i  (addr_pad_low_i),
      .lvl_mid_i  (addr_pad_mid_i),
      .lvl_high_i (addr_pad_high_i),
      .addr_o     (dec_addr)
   );

   // Waits for the pads to settle, then latches once and powers the pads down on the same edge.
   always_comb begin
      next_st         = st;
      next_cnt        = cnt;
      next_slave_addr = slave_addr_o;
      next_pad_enable = pad_enable_o;
      next_addr_valid = addr_valid_o;
      case (st)
         ST_SETTLE: begin
            next_pad_enable = 1'b1;
            next_cnt        = 8'(cnt + 8'h01);
            if (cnt == SETTLE_LAST) begin
               next_st = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            next_slave_addr = dec_addr;
            next_addr_valid = 1'b1;
            next_pad_enable = 1'b0;
            next_st         = ST_DONE;
         end
         ST_DONE: begin
            next_pad_enable = 1'b0;
         end
         default: begin
            next_st = ST_SETTLE;
         end
      endcase
   end

   // Reset restarts the whole sequence, so pads are resampled.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st           <= ST_SETTLE;
         cnt          <= 8'h00;
         slave_addr_o <= ADDR_RESET;
         pad_enable_o <= 1'b1;
         addr_valid_o <= 1'b0;
      end else begin
         st           <= next_st;
         cnt          <= next_cnt;
         slave_addr_o <= next_slave_addr;
         pad_enable_o <= next_pad_enable;
         addr_valid_o <= next_addr_valid;
      end
   end

   // ===========================================================================
   // LED output gate
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         led_gate_o <= 1'b0;
      end else begin
         led_gate_o <= ~led_enable_n_i;
      end
   end

   // ===========================================================================
   // Address byte receiver
   typedef enum logic [3:0] {
      BS_IDLE = 4'b0001,
      BS_ADDR = 4'b0010,
      BS_ACK  = 4'b0100,
      BS_SKIP = 4'b1000
   } bus_st_t;

   bus_st_t    bst;
   bus_st_t    next_bst;
   logic       scl_q;
   logic       sda_q;
   logic [3:0] bcnt;
   logic [3:0] next_bcnt;
   logic [7:0] sh;
   logic [7:0] next_sh;
   logic       next_sda_oe_n;
   logic       next_match;
   logic       start_c;
   logic       stop_c;
   logic       rise;
   logic       fall;

   assign start_c = scl_i && scl_q && sda_q && !sda_i;
   assign stop_c  = scl_i && scl_q && !sda_q && sda_i;
   assign rise    = scl_i && !scl_q;
   assign fall    = !scl_i && scl_q;

   // Shifts the first byte after START and drives ACK on a match.
   always_comb begin
      next_bst      = bst;
      next_bcnt     = bcnt;
      next_sh       = sh;
      next_sda_oe_n = sda_oe_n_o;
      next_match    = addr_match_o;
      if (start_c) begin
         next_bst      = addr_valid_o ? BS_ADDR : BS_SKIP;
         next_bcnt     = BIT_ZERO;
         next_sda_oe_n = 1'b1;
         next_match    = 1'b0;
      end else if (stop_c) begin
         next_bst      = BS_IDLE;
         next_sda_oe_n = 1'b1;
      end else begin
         case (bst)
            BS_ADDR: begin
               if (rise) begin
                  next_sh   = {sh[6:0], sda_i};
                  next_bcnt = 4'(bcnt + 4'h1);
               end
               if (fall && bcnt == BIT_ACK) begin
                  if (sh[7:1] == slave_addr_o) begin
                     next_sda_oe_n = 1'b0;
                     next_match    = 1'b1;
                     next_bst      = BS_ACK;
                  end else begin
                     next_bst = BS_SKIP;
                  end
               end
            end
            BS_ACK: begin
               if (fall) begin
                  next_sda_oe_n = 1'b1;
                  next_bst      = BS_IDLE;
               end
            end
            BS_IDLE, BS_SKIP: begin
               next_sda_oe_n = 1'b1;
            end
            default: begin
               next_bst = BS_IDLE;
            end
         endcase
      end
   end

   // Registers the receiver state.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bst          <= BS_IDLE;
         scl_q        <= 1'b1;
         sda_q        <= 1'b1;
         bcnt         <= BIT_ZERO;
         sh           <= 8'h00;
         sda_oe_n_o   <= 1'b1;
         sda_o        <= 1'b0;
         addr_match_o <= 1'b0;
      end else begin
         bst          <= next_bst;
         scl_q        <= scl_i;
         sda_q        <= sda_i;
         bcnt         <= next_bcnt;
         sh           <= next_sh;
         sda_oe_n_o   <= next_sda_oe_n;
         sda_o        <= 1'b0;
         addr_match_o <= next_match;
      end
   end

   // ===========================================================================
   // Checks
   // Latest cycle, counted from the first edge after reset release, for a latched address.
   localparam int LATCH_WAIT_MAX = 60;

   AST_PAD_OFF: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      addr_valid_o |-> !pad_enable_o)
      else $error("Pads powered while address latched.");
   AST_LATCH_STABLE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      addr_valid_o && $past(addr_valid_o) |-> $stable(slave_addr_o))
      else $error("Latched address changed.");
   AST_ADDR_RANGE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      addr_valid_o |-> (slave_addr_o >= 7'h01 && slave_addr_o <= 7'h7D))
      else $error("Address out of range.");
   AST_LATCH_TIME: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> ##[1:LATCH_WAIT_MAX] addr_valid_o)
      else $error("Address not latched in time.");
   AST_GATE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      led_enable_n_i |=> !led_gate_o)
      else $error("LED gate open while enable high.");
   AST_ACK_MATCH: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      $fell(sda_oe_n_o) |-> addr_match_o && sh[7:1] == slave_addr_o)
      else $error("ACK without address match.");
   AST_RELEASE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !addr_valid_o |-> sda_oe_n_o)
      else $error("SDA driven before address latched.");
   AST_DECODE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      st == ST_SAMPLE |=> slave_addr_o == $past(dec_addr))
      else $error("Latched value differs from pad decode.");
endmodule : quinary_i2c_address_select
`default_nettype wire

// File: rtl/addr_sel_pkg.sv
// Constants for the quinary slave-address select block.
// Assumes a single 40 MHz core clock and an asynchronous active-low reset.
package addr_sel_pkg;
   // ==========================================================================
   // Pad level codes
   localparam logic [2:0] LEVEL_GND               = 3'h0;
   localparam logic [2:0] LEVEL_PULLED_DOWN       = 3'h1;
   localparam logic [2:0] LEVEL_FLOATING          = 3'h2;
   localparam logic [2:0] LEVEL_PULLED_UP         = 3'h3;
   localparam logic [2:0] LEVEL_VDD               = 3'h4;
   localparam int         LEVEL_COUNT             = 5;
   localparam int         PAD_COUNT               = 3;
   localparam int         LEVEL_W                 = 3;
   // ==========================================================================
   // Address arithmetic
   localparam int         ADDR_W                  = 7;
   localparam logic [6:0] ADDR_BASE               = 7'h01;
   localparam logic [6:0] RADIX_LOW               = 7'h01;
   localparam logic [6:0] RADIX_MID               = 7'h05;
   localparam logic [6:0] RADIX_HIGH              = 7'h19;
   localparam logic [6:0] ADDR_RESET              = 7'h00;
   // ==========================================================================
   // Timing: pads settle this long after reset release before sampling.
   localparam int         CLK_HZ                  = 40000000;
   localparam int         SETTLE_NS               = 1000;
   localparam int         SETTLE_CYC              = (SETTLE_NS * (CLK_HZ / 1000000)) / 1000;
   localparam logic [7:0] SETTLE_LAST             = 8'(SETTLE_CYC - 1);
   // ==========================================================================
   // Serial frame constants
   localparam logic [3:0] BIT_ACK                 = 4'h8;
   localparam logic [3:0] BIT_ZERO                = 4'h0;
endpackage : addr_sel_pkg

// File: rtl/level_decode.sv
// Clamps the level codes of three five-level pads and weights them into an address.
// Assumes the pad comparator outputs are synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module level_decode (
   // Clock and reset.
   input  wire logic                             core_clk_i,
   input  wire logic                             rst_n_i,
   // Per-pad level codes.
   input  wire logic [addr_sel_pkg::LEVEL_W-1:0] lvl_low_i,
   input  wire logic [addr_sel_pkg::LEVEL_W-1:0] lvl_mid_i,
   input  wire logic [addr_sel_pkg::LEVEL_W-1:0] lvl_high_i,
   // Registered address.
   output logic      [addr_sel_pkg::ADDR_W-1:0]  addr_o
);
   import addr_sel_pkg::*;

   logic [ADDR_W-1:0] next_addr;

   // Clamps an out-of-range comparator code to the top level.
   function automatic logic [6:0] clamp(input logic [2:0] l);
      clamp = (l > LEVEL_VDD) ? {4'h0, LEVEL_VDD} : {4'h0, l};
   endfunction : clamp

   // Address is one plus the base-five pad value, third pad most significant.
   always_comb begin
      next_addr = 7'(ADDR_BASE + clamp(lvl_high_i) * RADIX_HIGH
                  + clamp(lvl_mid_i) * RADIX_MID + clamp(lvl_low_i) * RADIX_LOW);
   end

   // Registers the decoded address.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr_o <= ADDR_RESET;
      end else begin
         addr_o <= next_addr;
      end
   end
endmodule : level_decode
`default_nettype wire

// File: sim/i2c_ctrl_model.sv
// Behavioural I2C bus controller that sends one address byte per transfer.
// Assumes an open-drain SDA wire resolved by the bench with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
   // Clock and resolved bus line.
   input  wire logic core_clk_i,
   input  wire logic sda_line_i,
   // Driven bus lines, high means released.
   output logic      scl_o,
   output logic      sda_o
);
   // ==========================================================================
   // Bus idles released so the target sees no START before the first transfer.
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   // Waits whole cycles, then steps just past the edge.
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #2;
   endtask : tick

   // START, address byte first, ACK clock, then STOP.
   task automatic send_addr(input logic [7:0] byte_v, output logic ack);
      sda_o = 1'b0;
      tick(4);
      scl_o = 1'b0;
      tick(4);
      for (int i = 7; i >= 0; i--) begin
         sda_o = byte_v[i];
         tick(2);
         scl_o = 1'b1;
         tick(4);
         scl_o = 1'b0;
         tick(2);
      end
      sda_o = 1'b1;
      tick(4);
      scl_o = 1'b1;
      tick(2);
      ack = ~sda_line_i;
      tick(2);
      scl_o = 1'b0;
      tick(4);
      sda_o = 1'b0;
      tick(2);
      scl_o = 1'b1;
      tick(4);
      sda_o = 1'b1;
      tick(4);
   endtask : send_addr
endmodule : i2c_ctrl_model
`default_nettype wire

// File: sim/quinary_i2c_address_select_test.sv
// Self-checking bench for the quinary address select block.
// Assumes the controller model drives SCL and SDA; SDA has a pull-up.
`timescale 1ns/1ps
`default_nettype none
module quinary_i2c_address_select_test;
   import addr_sel_pkg::*;
   logic               core_clk_i, rst_n_i, led_enable_n_i, scl, m_sda;
   logic               pad_enable, led_gate, sda_out, sda_oe_n, addr_valid, addr_match;
   logic [LEVEL_W-1:0] p_lo, p_mi, p_hi;
   logic [ADDR_W-1:0]  slave_addr, exp_a, other;
   logic               ack, pulled, rw;
   wire logic          sda_line;
   int                 err_count, n_checks, cycles, seed;
   // ==========================================================================
   // Open-drain wire: low if either party pulls it.
   assign sda_line = m_sda & (sda_oe_n | sda_out);

   quinary_i2c_address_select dut_u (.core_clk_i, .rst_n_i, .addr_pad_low_i(p_lo),
      .addr_pad_mid_i(p_mi), .addr_pad_high_i(p_hi), .pad_enable_o(pad_enable),
      .led_enable_n_i, .led_gate_o(led_gate), .scl_i(scl), .sda_i(sda_line),
      .sda_o(sda_out), .sda_oe_n_o(sda_oe_n), .slave_addr_o(slave_addr),
      .addr_valid_o(addr_valid), .addr_match_o(addr_match));
   i2c_ctrl_model ctrl_u (.core_clk_i, .sda_line_i(sda_line), .scl_o(scl), .sda_o(m_sda));

   // Clock, SDA pull watch and hang limit.
   initial core_clk_i = 1'b0;
   always #12.5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cycles++;
      if (sda_oe_n === 1'b0) pulled = 1'b1;
      if (cycles == 20000) begin
         err_count++;
         report_and_stop();
      end
   end

   // Expected address and random level picks; codes above supply count as supply.
   function automatic int lvl(input logic [2:0] v);
      return (v > 3'h4) ? 4 : int'(v);
   endfunction : lvl
   function automatic logic [6:0] exp_addr(input logic [2:0] h, m, l);
      return 7'(1 + 25 * lvl(h) + 5 * lvl(m) + lvl(l));
   endfunction : exp_addr
   function automatic logic [2:0] rnd5();
      return 3'(($random(seed) & 32'h7FFF_FFFF) % 5);
   endfunction : rnd5

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #2;
   endtask : tick

   // Resets with given pad levels and waits for the latched address.
   // An early frame, started before the latch, must stay unanswered.
   task automatic do_reset(input logic [2:0] h, m, l, input bit early = 1'b0);
      rst_n_i = 1'b0;
      p_hi = h;
      p_mi = m;
      p_lo = l;
      tick(2);
      check("pad_enable_rst", 8'h01, {7'h00, pad_enable});
      check("addr_valid_rst", 8'h00, {7'h00, addr_valid});
      rst_n_i = 1'b1;
      if (early) begin
         ctrl_u.send_addr({exp_addr(h, m, l), 1'b0}, ack);
         check("ack_early", 8'h00, {7'h00, ack});
         check("match_early", 8'h00, {7'h00, addr_match});
      end
      for (int i = 0; i < 200 && addr_valid !== 1'b1; i++) tick(1);
      exp_a = exp_addr(h, m, l);
      check("slave_addr", {1'b0, exp_a}, {1'b0, slave_addr});
      check("pad_enable_off", 8'h00, {7'h00, pad_enable});
   endtask : do_reset

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   // Main sequence: corner pad sets first, then random ones.
   initial begin
      seed = 32'h4785;
      err_count = 0;
      n_checks = 0;
      cycles = 0;
      pulled = 1'b0;
      rst_n_i = 1'b0;
      led_enable_n_i = 1'b1;
      {p_hi, p_mi, p_lo} = '0;
      for (int t = 0; t < 12; t++) begin
         if (t == 0) do_reset(3'h0, 3'h0, 3'h0);
         else if (t == 1) do_reset(3'h4, 3'h4, 3'h4);
         else if (t == 2) do_reset(3'h0, 3'h1, 3'h1);
         else if (t == 3) do_reset(3'h7, 3'h5, 3'h6, 1'b1);
         else do_reset(rnd5(), rnd5(), rnd5());
         p_hi = rnd5();
         p_lo = rnd5();
         tick(10);
         check("addr_hold", {1'b0, exp_a}, {1'b0, slave_addr});
         check("pad_hold", 8'h00, {7'h00, pad_enable});
         led_enable_n_i = 1'($random(seed));
         tick(2);
         check("led_gate", {7'h00, ~led_enable_n_i}, {7'h00, led_gate});
         rw = 1'($random(seed));
         ctrl_u.send_addr({exp_a, rw}, ack);
         check("ack_match", 8'h01, {7'h00, ack});
         check("addr_match", 8'h01, {7'h00, addr_match});
         other = exp_a ^ (7'h01 << (t % 7));
         pulled = 1'b0;
         ctrl_u.send_addr({other, rw}, ack);
         check("ack_other", 8'h00, {7'h00, ack});
         check("match_other", 8'h00, {7'h00, addr_match});
         check("sda_pulled", 8'h00, {7'h00, pulled});
      end
      report_and_stop();
   end
endmodule : quinary_i2c_address_select_test
`default_nettype wire
